// ### rtl/tws_cfg.svh
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Slave address byte layout
`define TWS_TYPE_HI 7
`define TWS_TYPE_LO 4
`define TWS_PAGE_HI 3
`define TWS_PAGE_LO 1
`define TWS_RW_BIT 0
// Device type code; value is arbitrary
`define TWS_DEV_TYPE 4'h5

// Array geometry
`define TWS_ADDR_W 11
`define TWS_MEM_DEPTH 2048
`define TWS_ADDR_RST 11'h000
`define TWS_ADDR_LAST 11'h7FF

// Bit counting and buffering
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_LAST_BIT 4'h7
`define TWS_FIFO_DEPTH 16

// Idle level of synchronised pins: wp, sda, scl
`define TWS_SYNC_RST 3'h3

`endif

// ### rtl/tws_fifo.sv
`timescale 1ns/10ps

module tws_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // Honest flags straight from the occupancy count
   assign inReady = count_r != DEPTH[AW:0];
   assign outValid = count_r != '0;
   assign outData = store[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage has no reset; only pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtr_r] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ### rtl/tws_mem_array.sv
`timescale 1ns/10ps
`include "tws_cfg.svh"

module tws_mem_array (
   // Clock
   input wire logic clk,
   // Array port
   tws_mem_if.mem port
);
   logic [7:0] cells [0:`TWS_MEM_DEPTH-1];

   // Single port: a read takes the cycle, so buffered writes stall
   assign port.wrReady = !port.rdReq;

   // Synchronous read or write
   always_ff @(posedge clk) begin
      if (port.rdReq) begin
         port.rdData <= cells[port.rdAddr];
      end else if (port.wrValid) begin
         cells[port.wrReq.addr] <= port.wrReq.data;
      end
   end
endmodule

// ### rtl/tws_mem_if.sv
`timescale 1ns/10ps

interface tws_mem_if;
   // Write channel, fed from the buffer
   logic wrValid;
   logic wrReady;
   tws_pkg::tws_wreq_type wrReq;
   // Read channel, one cycle latency
   logic rdReq;
   logic [10:0] rdAddr;
   logic [7:0] rdData;

   modport ctrl (output wrValid, output wrReq, output rdReq, output rdAddr, input wrReady, input rdData);
   modport mem (input wrValid, input wrReq, input rdReq, input rdAddr, output wrReady, output rdData);
endinterface

// ### rtl/tws_mem_slave.sv
`timescale 1ns/10ps
`include "tws_cfg.svh"

module tws_mem_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Two-wire bus
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Write protect
   input wire logic wp
);
   localparam logic [2:0] SyncRst = `TWS_SYNC_RST;

   tws_mem_if memIf ();

   tws_pkg::tws_state_type state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [2:0] page_r;
   logic rw_r;
   logic ackOk_r;
   logic sdaOe_r;
   logic sdaOut_r;
   logic [10:0] addr_r;
   logic [2:0] pinSync;
   logic sclSync;
   logic sdaSync;
   logic wpSync;
   logic sclPrev_r;
   logic sdaPrev_r;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   logic [7:0] rxByte;
   logic lastRx;
   logic byteIn;
   logic wrAccept;
   logic fifoInReady;
   tws_pkg::tws_wreq_type fifoIn;

   // Device type check, used by engine and address latch
   function automatic logic typeOk(input logic [7:0] b);
      typeOk = b[`TWS_TYPE_HI:`TWS_TYPE_LO] == `TWS_DEV_TYPE;
   endfunction

   // Next sequential address, rolls from last back to zero
   function automatic logic [10:0] nextAddr(input logic [10:0] a);
      nextAddr = (a == `TWS_ADDR_LAST) ? `TWS_ADDR_RST : a + 11'h001;
   endfunction

   // Two-stage synchronisers for the asynchronous pins
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         logic meta_r;
         logic sync_r;
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_r <= SyncRst[gi];
               sync_r <= SyncRst[gi];
            end else begin
               meta_r <= (gi == 0) ? scl : (gi == 1) ? sdaIn : wp;
               sync_r <= meta_r;
            end
         end
         assign pinSync[gi] = sync_r;
      end
   endgenerate

   assign sclSync = pinSync[0];
   assign sdaSync = pinSync[1];
   assign wpSync = pinSync[2];

   // Previous levels for edge and condition detection
   always_ff @(posedge clk) begin
      if (rst) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclSync;
         sdaPrev_r <= sdaSync;
      end
   end

   // Bus events; Start and Stop need SCL high on both samples
   assign sclRise = sclSync && !sclPrev_r;
   assign sclFall = !sclSync && sclPrev_r;
   assign startDet = sclSync && sclPrev_r && sdaPrev_r && !sdaSync;
   assign stopDet = sclSync && sclPrev_r && !sdaPrev_r && sdaSync;

   // Incoming byte assembled MSB first
   assign rxByte = {shift_r[6:0], sdaSync};
   assign lastRx = sclRise && (bitCnt_r == `TWS_LAST_BIT);
   assign byteIn = sclFall && (bitCnt_r == `TWS_BITS_PER_BYTE);
   // Write taken at the eighth bit, unless protected or buffer full
   assign wrAccept = (state_r == tws_pkg::TWS_WDATA) && lastRx && !wpSync && fifoInReady;
   assign fifoIn = '{addr: addr_r, data: rxByte};

   // Protocol engine
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= tws_pkg::TWS_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         page_r <= 3'h0;
         rw_r <= 1'b0;
         ackOk_r <= 1'b0;
         sdaOe_r <= 1'b0;
      end else if (startDet) begin
         state_r <= tws_pkg::TWS_DEV;
         bitCnt_r <= 4'h0;
         sdaOe_r <= 1'b0;
      end else if (stopDet) begin
         state_r <= tws_pkg::TWS_IDLE;
         sdaOe_r <= 1'b0;
      end else begin
         case (state_r)
            tws_pkg::TWS_DEV, tws_pkg::TWS_WADDR, tws_pkg::TWS_WDATA: begin
               if (sclRise) begin
                  shift_r <= rxByte;
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
               if (lastRx) begin
                  ackOk_r <= wrAccept;
               end
               if (byteIn) begin
                  bitCnt_r <= 4'h0;
                  if (state_r == tws_pkg::TWS_DEV) begin
                     if (typeOk(shift_r)) begin
                        page_r <= shift_r[`TWS_PAGE_HI:`TWS_PAGE_LO];
                        rw_r <= shift_r[`TWS_RW_BIT];
                        sdaOe_r <= 1'b1;
                        state_r <= tws_pkg::TWS_DEV_ACK;
                     end else begin
                        state_r <= tws_pkg::TWS_IDLE;
                     end
                  end else if (state_r == tws_pkg::TWS_WADDR) begin
                     sdaOe_r <= 1'b1;
                     state_r <= tws_pkg::TWS_WADDR_ACK;
                  end else begin
                     sdaOe_r <= ackOk_r;
                     state_r <= tws_pkg::TWS_WDATA_ACK;
                  end
               end
            end
            tws_pkg::TWS_DEV_ACK: begin
               if (sclFall) begin
                  bitCnt_r <= 4'h0;
                  if (rw_r) begin
                     shift_r <= memIf.rdData;
                     sdaOe_r <= !memIf.rdData[7];
                     state_r <= tws_pkg::TWS_RDATA;
                  end else begin
                     sdaOe_r <= 1'b0;
                     state_r <= tws_pkg::TWS_WADDR;
                  end
               end
            end
            tws_pkg::TWS_WADDR_ACK: begin
               if (sclFall) begin
                  sdaOe_r <= 1'b0;
                  state_r <= tws_pkg::TWS_WDATA;
               end
            end
            tws_pkg::TWS_WDATA_ACK: begin
               if (sclFall) begin
                  sdaOe_r <= 1'b0;
                  state_r <= ackOk_r ? tws_pkg::TWS_WDATA : tws_pkg::TWS_IDLE;
               end
            end
            tws_pkg::TWS_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_r == `TWS_LAST_BIT) begin
                     sdaOe_r <= 1'b0;
                     state_r <= tws_pkg::TWS_RACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sdaOe_r <= !shift_r[6];
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
            end
            tws_pkg::TWS_RACK: begin
               if (sclRise) begin
                  ackOk_r <= !sdaSync;
               end
               if (sclFall) begin
                  bitCnt_r <= 4'h0;
                  if (ackOk_r) begin
                     shift_r <= memIf.rdData;
                     sdaOe_r <= !memIf.rdData[7];
                     state_r <= tws_pkg::TWS_RDATA;
                  end else begin
                     state_r <= tws_pkg::TWS_IDLE;
                  end
               end
            end
            default: begin
               state_r <= tws_pkg::TWS_IDLE;
            end
         endcase
      end
   end

   // Address latch; Start and Stop never share a cycle with an SCL edge
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r <= `TWS_ADDR_RST;
      end else if (state_r == tws_pkg::TWS_DEV && byteIn && typeOk(shift_r)) begin
         addr_r <= {shift_r[`TWS_PAGE_HI:`TWS_PAGE_LO], addr_r[7:0]};
      end else if (state_r == tws_pkg::TWS_WADDR && byteIn) begin
         addr_r <= {page_r, shift_r};
      end else if (wrAccept) begin
         addr_r <= nextAddr(addr_r);
      end else if (state_r == tws_pkg::TWS_RDATA && sclFall && bitCnt_r == `TWS_LAST_BIT) begin
         addr_r <= nextAddr(addr_r);
      end
   end

   // Array read fetched on the ninth rising edge, long before it is needed
   assign memIf.rdReq = sclRise && ((state_r == tws_pkg::TWS_DEV_ACK && rw_r)
                        || (state_r == tws_pkg::TWS_RACK && !sdaSync));
   assign memIf.rdAddr = addr_r;

   // Write buffer between engine and array
   tws_fifo #(
      .WIDTH($bits(tws_pkg::tws_wreq_type)),
      .DEPTH(`TWS_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .inValid(wrAccept),
      .inReady(fifoInReady),
      .inData(fifoIn),
      .outValid(memIf.wrValid),
      .outReady(memIf.wrReady),
      .outData(memIf.wrReq)
   );

   tws_mem_array u_array (
      .clk(clk),
      .port(memIf.mem)
   );

   // Open drain: data level is always low, enable does the signalling
   always_ff @(posedge clk) begin
      if (rst) begin
         sdaOut_r <= 1'b0;
      end else begin
         sdaOut_r <= 1'b0;
      end
   end

   assign sdaOut = sdaOut_r;
   assign sdaOe = sdaOe_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_reset_idle: assert property ($fell(rst) |-> addr_r == `TWS_ADDR_RST && state_r == tws_pkg::TWS_IDLE)
      else $error("reset left address or state");
   chk_start_abort: assert property (startDet |=> state_r == tws_pkg::TWS_DEV && !sdaOe_r && bitCnt_r == 4'h0)
      else $error("start did not restart address decode");
   chk_stop_abort: assert property (stopDet |=> state_r == tws_pkg::TWS_IDLE && !sdaOe_r)
      else $error("stop did not abort");
   chk_type_reject: assert property (state_r == tws_pkg::TWS_DEV && byteIn && !typeOk(shift_r)
      |=> state_r == tws_pkg::TWS_IDLE && !sdaOe_r)
      else $error("foreign device type acknowledged");
   chk_word_addr: assert property (state_r == tws_pkg::TWS_WADDR && byteIn
      |=> addr_r == {page_r, $past(shift_r)} && sdaOe_r)
      else $error("word address not latched");
   chk_wp_hold: assert property (state_r == tws_pkg::TWS_WDATA && lastRx && wpSync
      |=> addr_r == $past(addr_r) && !ackOk_r)
      else $error("protected write moved address");
   chk_wr_incr: assert property (wrAccept |=> addr_r == nextAddr($past(addr_r)))
      else $error("write address not advanced");
   chk_wp_noack: assert property (state_r == tws_pkg::TWS_WDATA_ACK && !ackOk_r |-> !sdaOe_r)
      else $error("protected byte acknowledged");
   chk_read_msb: assert property (state_r == tws_pkg::TWS_DEV_ACK && rw_r && sclFall && !startDet
      |=> state_r == tws_pkg::TWS_RDATA && sdaOe_r == !shift_r[7])
      else $error("read did not start with MSB");
   chk_rack_free: assert property (state_r == tws_pkg::TWS_RACK |-> !sdaOe_r)
      else $error("line driven during master acknowledge");

   cov_write_byte: cover property (wrAccept ##[1:1000] state_r == tws_pkg::TWS_WDATA_ACK && sdaOe_r);
   cov_seq_read: cover property (state_r == tws_pkg::TWS_RACK && ackOk_r ##1 state_r == tws_pkg::TWS_RDATA);
   cov_wp_refuse: cover property (state_r == tws_pkg::TWS_WDATA && lastRx && wpSync);
endmodule

// ### rtl/tws_pkg.sv
package tws_pkg;

   // Protocol engine states, Gray coded along the write path; TWS_DEV_ACK to TWS_RDATA changes three bits
   typedef enum logic [3:0] {
      TWS_IDLE = 4'h0,
      TWS_DEV = 4'h1,
      TWS_DEV_ACK = 4'h3,
      TWS_WADDR = 4'h2,
      TWS_WADDR_ACK = 4'h6,
      TWS_WDATA = 4'h7,
      TWS_WDATA_ACK = 4'h5,
      TWS_RDATA = 4'h4,
      TWS_RACK = 4'hC
   } tws_state_type;

   // One buffered array write
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0] data;
   } tws_wreq_type;

endpackage

// ### test/test_tws_mem_slave.sv
`timescale 1ns/10ps
`include "tws_cfg.svh"

`define CHECK(got, exp) begin checkCount++; if ((got) !== (exp)) begin errorCnt++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end

module test_tws_mem_slave;
   logic clk;
   logic rst;
   logic wp;
   logic scl;
   logic sdaDrv;
   logic sdaOut;
   logic sdaOe;
   logic sda;
   logic ack;
   logic [7:0] rd;
   int errorCnt;
   int checkCount;

   // Open-drain wire: either party may pull low, otherwise the pull-up wins
   assign sda = (sdaOe ? sdaOut : 1'b1) & sdaDrv;

   tws_mem_slave dut_u (
      .clk(clk),
      .rst(rst),
      .scl(scl),
      .sdaIn(sda),
      .sdaOut(sdaOut),
      .sdaOe(sdaOe),
      .wp(wp)
   );

   tws_bus_master master_u (
      .clk(clk),
      .scl(scl),
      .sdaDrv(sdaDrv),
      .sda(sda)
   );

   // 125 MHz clock
   initial clk = 1'b0;
   always #4 clk = ~clk;

   // Slave address byte: device type, page, direction
   function automatic logic [7:0] devAddr(input logic [2:0] page, input logic dir);
      return {`TWS_DEV_TYPE, page, dir};
   endfunction

   // Write header: slave address then word address, bus left mid-transaction
   task automatic setAddr(input logic [2:0] page, input logic [7:0] word);
      master_u.startCond();
      master_u.sendByte(devAddr(page, 1'b0), ack);
      `CHECK(ack, 1'b1)
      master_u.sendByte(word, ack);
      `CHECK(ack, 1'b1)
   endtask

   // Sends one data byte and compares the acknowledge
   task automatic putByte(input logic [7:0] d, input logic expAck);
      master_u.sendByte(d, ack);
      `CHECK(ack, expAck)
   endtask

   // Starts a read at the held address, page from the address byte
   task automatic readHead(input logic [2:0] page);
      master_u.startCond();
      master_u.sendByte(devAddr(page, 1'b1), ack);
      `CHECK(ack, 1'b1)
   endtask

   // Reads one byte, acknowledging when more follow
   task automatic getByte(input logic more, input logic [7:0] exp);
      master_u.recvByte(more, rd);
      `CHECK(rd, exp)
   endtask

   // Ends the transaction; the device must let go of the data line
   task automatic endTrans();
      master_u.stopCond();
      `CHECK(sdaOe, 1'b0)
   endtask

   // Single exit point for both the normal end and the watchdog
   task automatic stopTest();
      $display("Comparisons %0d, mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence; bus traffic runs back to back, no busy gaps after writes
   initial begin
      rst = 1'b1;
      wp = 1'b0;
      errorCnt = 0;
      checkCount = 0;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      `CHECK(sdaOe, 1'b0)
      // Foreign device type is ignored
      master_u.startCond();
      master_u.sendByte({`TWS_DEV_TYPE + 4'h1, 3'h0, 1'b0}, ack);
      `CHECK(ack, 1'b0)
      endTrans();
      // Sequential write through the top of the array
      setAddr(3'h7, 8'hFE);
      putByte(8'hA5, 1'b1);
      putByte(8'h3C, 1'b1);
      putByte(8'h0F, 1'b1);
      putByte(8'h96, 1'b1);
      endTrans();
      // Selective read: write header abandoned by a repeated start
      setAddr(3'h7, 8'hFE);
      readHead(3'h7);
      getByte(1'b1, 8'hA5);
      getByte(1'b1, 8'h3C);
      getByte(1'b0, 8'h0F);
      endTrans();
      // Current address read continues from the held low byte on a new page
      readHead(3'h0);
      getByte(1'b0, 8'h96);
      endTrans();
      // Protected write: refused and address left where the header put it
      wp = 1'b1;
      setAddr(3'h0, 8'h01);
      putByte(8'h55, 1'b0);
      endTrans();
      wp = 1'b0;
      readHead(3'h0);
      getByte(1'b0, 8'h96);
      endTrans();
      // Byte cut short by a repeated start leaves the array untouched
      setAddr(3'h0, 8'h01);
      repeat (5) master_u.bitSlot(1'b0, rd[0]);
      readHead(3'h0);
      getByte(1'b0, 8'h96);
      endTrans();
      stopTest();
   end

   // Watchdog, well beyond the few tens of bytes the sequence moves
   initial begin
      repeat (80000) @(posedge clk);
      errorCnt++;
      stopTest();
   end
endmodule

// ### test/tws_bus_master.sv
`timescale 1ns/10ps

// Behavioural two-wire bus master; it owns the clock line and shares the data line
module tws_bus_master #(
   parameter int QUARTER = 20
) (
   // Clock
   input wire logic clk,
   // Bus lines, data released when sdaDrv is high
   output logic scl,
   output logic sdaDrv,
   input wire logic sda
);
   // Both lines idle high, as the pull-ups leave them
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   // Waits whole cycles; every change lands just after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One bit slot: data set while the clock is low, sampled mid-high
   task automatic bitSlot(input logic b, output logic r);
      sdaDrv = b;
      tick(QUARTER);
      scl = 1'b1;
      tick(QUARTER);
      r = sda;
      tick(QUARTER);
      scl = 1'b0;
      tick(QUARTER);
   endtask

   // Start or repeated start: data falls while the clock is high
   task automatic startCond();
      sdaDrv = 1'b1;
      tick(QUARTER);
      scl = 1'b1;
      tick(QUARTER);
      sdaDrv = 1'b0;
      tick(QUARTER);
      scl = 1'b0;
      tick(QUARTER);
   endtask

   // Stop: data rises while the clock is high, then both lines rest high
   task automatic stopCond();
      sdaDrv = 1'b0;
      tick(QUARTER);
      scl = 1'b1;
      tick(QUARTER);
      sdaDrv = 1'b1;
      tick(QUARTER);
   endtask

   // Sends a byte and releases the line for the ninth slot
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(d[i], r);
      end
      bitSlot(1'b1, r);
      ack = ~r;
   endtask

   // Receives a byte; a withheld acknowledge tells the device to stop sending
   task automatic recvByte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(1'b1, d[i]);
      end
      bitSlot(~more, r);
   endtask
endmodule
